// *** verilog/fxr_pkg.sv ***
// constants, types and dummy-cycle lookup shared by both link ends
// Notes on behaviour
// - default dummies 8, 4 dual-io, 6 quad
// - host programs enough dummy cycles for reads
// - never two drivers on data lines
// - no dual-io double-rate read in quad mode
// - 8-bit register: drive, pattern, four flags
// - parameter writes leave the four flags alone
// - 85h writes nonvolatile copy, 83h volatile
// - drive encodings, 111 default, 000/100 reserved
// - bit 0 mirrors the busy status bit
// - pattern enable: 0 off, 1 on, resets 0
// - protection flag on protected erase or program
// - program flag on program or register failure
// - erase flag on erase or register failure
// - program commands: fail or protected sets flags
// - info row program: fail or locked region
// - bad mode-lock change sets program and protect
// - password mismatch sets program and protect
// - register update: erase step, program step flags
// - locked status write sets protect and erase
// - erase commands: fail or protected sets flags
// - chip erase flags only on block protect bits
// - error flags stick until clear or reset
// - commands still run while flags are set
package fxr_pkg;
	// register layout
	localparam int EXT_W = 8;
	localparam int DRV_HI = 7;
	localparam int DRV_LO = 5;
	localparam int TP_BIT = 4;
	localparam int BUSY_BIT = 0;
	localparam int WR_W = 4; // writable upper bits
	localparam logic [3:0] WR_DEFAULT = 4'he; // drive 111, pattern off
	// error flag indices inside the 3-bit flag group
	localparam int F_E = 2;
	localparam int F_P = 1;
	localparam int F_PROT = 0;
	localparam int FLAG_W = 3;
	// drive strength encodings
	localparam logic [2:0] DRV_90 = 3'h1;
	localparam logic [2:0] DRV_60 = 3'h2;
	localparam logic [2:0] DRV_45 = 3'h3;
	localparam logic [2:0] DRV_20 = 3'h5;
	localparam logic [2:0] DRV_15 = 3'h6;
	localparam logic [2:0] DRV_30 = 3'h7;
	localparam logic [2:0] DRV_RSV_A = 3'h0;
	localparam logic [2:0] DRV_RSV_B = 3'h4;
	// opcodes
	localparam logic [7:0] OP_SET_NV = 8'h85;
	localparam logic [7:0] OP_SET_V = 8'h83;
	localparam logic [7:0] OP_READ_EXT = 8'h81;
	localparam logic [7:0] OP_CLEAR_ERR = 8'h82;
	localparam logic [7:0] OP_SOFT_RST = 8'h99;
	localparam logic [7:0] OP_DDR_DUAL_A = 8'hbd;
	localparam logic [7:0] OP_DDR_DUAL_B = 8'hbe;
	// dummy cycle counts
	localparam logic [3:0] DUMMY_8 = 4'h8;
	localparam logic [3:0] DUMMY_6 = 4'h6;
	localparam logic [3:0] DUMMY_4 = 4'h4;
	localparam logic [3:0] DUMMY_NONE = 4'h0;
	// link framing
	localparam int FRAME_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam int SYNC_W = 4;
	// host register offsets
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_DUMMY = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_RX = 4'hc;
	// outcome kinds reported by the array engine
	typedef enum logic [2:0] {
		EV_PROGRAM = 3'b000,
		EV_INFO_PROG = 3'b001,
		EV_PROT_CFG = 3'b010,
		EV_UNLOCK = 3'b011,
		EV_NV_UPDATE = 3'b100,
		EV_STATUS_WRITE = 3'b101,
		EV_ERASE = 3'b110,
		EV_CHIP_ERASE = 3'b111
	} fxr_event_e;
	// host sequencer states
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_SHIFT = 2'b01,
		HS_TAIL = 2'b10,
		HS_GUARD = 2'b11
	} fxr_hstate_e;
	// default dummy cycles of a read opcode, none for others
	function automatic logic [3:0] dummy_for(input logic [7:0] op, input logic quad);
		logic [3:0] d;
		d = DUMMY_NONE;
		case (op)
			8'h0b, 8'h0c, 8'h0d, 8'h0e: d = quad ? DUMMY_6 : DUMMY_8;
			8'h3b, 8'h3c, 8'h6b, 8'h6c: d = quad ? DUMMY_NONE : DUMMY_8;
			8'hbb, 8'hbc, 8'hbd, 8'hbe: d = quad ? DUMMY_NONE : DUMMY_4;
			8'heb, 8'hec, 8'hed, 8'hee: d = DUMMY_6;
			default: d = DUMMY_NONE;
		endcase
		return d;
	endfunction : dummy_for
endpackage : fxr_pkg

// *** verilog/fxr_if.sv ***
// serial link between flash register device and host
interface fxr_if;
	logic sck; // link clock, made by host
	logic cs_n; // frame select, active low
	logic mosi; // host to device data
	logic miso; // device to host data
	logic miso_oe; // device drives miso
	// documented device end
	modport device (input sck, input cs_n, input mosi, output miso, output miso_oe);
	// controller end
	modport host (output sck, output cs_n, output mosi, input miso, input miso_oe);
endinterface : fxr_if

// *** verilog/fxr_device.sv ***
// extended read register and error flag logic on the device end
module fxr_device (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// link
	fxr_if.device link,
	// array engine status
	input wire logic busy_in,
	input wire logic quad_mode_in,
	input wire logic write_protect_n_in,
	input wire logic status_write_disable_in,
	input wire logic [3:0] block_protect_bits_in,
	// outcome report, one-cycle pulse
	input wire logic event_valid_in,
	input wire fxr_pkg::fxr_event_e event_kind_in,
	input wire logic erase_fail_in,
	input wire logic program_fail_in,
	input wire logic target_protected_in,
	// register state
	output logic [fxr_pkg::EXT_W-1:0] ext_params_out,
	output logic [2:0] drive_sel_out,
	output logic training_pattern_enable_out,
	output logic [3:0] dummy_cycles_out
);
	// pin synchronisers
	logic [fxr_pkg::SYNC_W-1:0] sync1; // first stage only
	logic [fxr_pkg::SYNC_W-1:0] sync2; // safe copies
	logic sck_prev; // edge detect
	logic cs_prev;
	// register state
	logic [fxr_pkg::WR_W-1:0] vol; // volatile writable bits
	logic [fxr_pkg::WR_W-1:0] nv; // nonvolatile copy
	logic [fxr_pkg::FLAG_W-1:0] flags; // e, p, protect
	logic reload; // pending copy of nv into vol
	// link state
	logic [4:0] bitcnt;
	logic [fxr_pkg::FRAME_BITS-2:0] shin;
	logic [7:0] opcode;
	logic [7:0] shout;
	logic miso_q;
	logic oe_q;
	// next values
	logic [fxr_pkg::WR_W-1:0] next_vol;
	logic [fxr_pkg::WR_W-1:0] next_nv;
	logic [fxr_pkg::FLAG_W-1:0] next_flags;
	logic next_reload;
	logic [4:0] next_bitcnt;
	logic [fxr_pkg::FRAME_BITS-2:0] next_shin;
	logic [7:0] next_opcode;
	logic [7:0] next_shout;
	logic next_miso;
	logic next_oe;
	logic [3:0] next_dummy;
	// decoded helpers
	logic sck_s;
	logic cs_s;
	logic mosi_s;
	logic wp_n_s;
	logic rise;
	logic fall;
	logic frame_end;
	logic [fxr_pkg::EXT_W-1:0] reg_val;
	logic [fxr_pkg::FLAG_W-1:0] ev_set;
	logic clr;
	logic [7:0] byte_in;

	assign sck_s = sync2[3];
	assign cs_s = sync2[2];
	assign mosi_s = sync2[1];
	assign wp_n_s = sync2[0];
	assign rise = sck_s & ~sck_prev & ~cs_s;
	assign fall = ~sck_s & sck_prev & ~cs_s;
	assign frame_end = cs_s & ~cs_prev;
	assign byte_in = {shin[6:0], mosi_s};
	// assembled register view, bit 0 is the live busy status
	assign reg_val = {vol, flags, busy_in};
	assign link.miso = miso_q;
	assign link.miso_oe = oe_q;

	// two-stage synchronisers for every pin
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			// idle pin levels: clock low, select high, data low, protect pin high
			sync1 <= 4'h5;
			sync2 <= 4'h5;
			sck_prev <= 1'b0;
			cs_prev <= 1'b1;
		end
		else
		begin
			sync1 <= {link.sck, link.cs_n, link.mosi, write_protect_n_in};
			sync2 <= sync1;
			sck_prev <= sync2[3];
			cs_prev <= sync2[2];
		end
	end

	// flag set terms from the reported outcome
	always_comb
	begin
		ev_set = 3'h0;
		if (event_valid_in)
		begin
			case (event_kind_in)
				fxr_pkg::EV_PROGRAM, fxr_pkg::EV_INFO_PROG, fxr_pkg::EV_PROT_CFG, fxr_pkg::EV_UNLOCK:
				begin
					// failure, protected target, locked row, bad lock bits, wrong password
					ev_set[fxr_pkg::F_P] = program_fail_in | target_protected_in;
					ev_set[fxr_pkg::F_PROT] = target_protected_in;
				end
				fxr_pkg::EV_NV_UPDATE:
				begin
					// internal erase then program of register bits
					ev_set[fxr_pkg::F_E] = erase_fail_in;
					ev_set[fxr_pkg::F_P] = program_fail_in;
				end
				fxr_pkg::EV_STATUS_WRITE:
				begin
					// locked when disable bit set and protect pin low
					ev_set[fxr_pkg::F_E] = erase_fail_in | (status_write_disable_in & ~wp_n_s);
					ev_set[fxr_pkg::F_P] = program_fail_in;
					ev_set[fxr_pkg::F_PROT] = status_write_disable_in & ~wp_n_s;
				end
				fxr_pkg::EV_ERASE:
				begin
					ev_set[fxr_pkg::F_E] = erase_fail_in | target_protected_in;
					ev_set[fxr_pkg::F_PROT] = target_protected_in;
				end
				fxr_pkg::EV_CHIP_ERASE:
				begin
					// sector locks alone never flag a chip erase
					ev_set[fxr_pkg::F_E] = erase_fail_in | (|block_protect_bits_in);
					ev_set[fxr_pkg::F_PROT] = |block_protect_bits_in;
				end
				default: ev_set = 3'h0;
			endcase
		end
	end

	// link decode and register updates
	always_comb
	begin
		next_vol = vol;
		next_nv = nv;
		next_reload = 1'b0;
		next_bitcnt = bitcnt;
		next_shin = shin;
		next_opcode = opcode;
		next_shout = shout;
		next_miso = miso_q;
		next_oe = oe_q;
		next_dummy = dummy_cycles_out;
		clr = 1'b0;
		// volatile copy takes the stored copy after reset
		if (reload)
			next_vol = nv;
		if (frame_end)
		begin
			// release the line when the frame closes
			next_bitcnt = 5'h0;
			next_oe = 1'b0;
		end
		else if (rise)
		begin
			next_shin = {shin[13:0], mosi_s};
			next_bitcnt = bitcnt + 5'h1;
			if (bitcnt == 5'(fxr_pkg::BYTE_BITS - 1))
			begin
				// opcode complete
				next_opcode = byte_in;
				next_dummy = fxr_pkg::dummy_for(byte_in, quad_mode_in);
				clr = (byte_in == fxr_pkg::OP_CLEAR_ERR) | (byte_in == fxr_pkg::OP_SOFT_RST);
				if (byte_in == fxr_pkg::OP_SOFT_RST)
					next_reload = 1'b1;
			end
			else if (bitcnt == 5'(fxr_pkg::FRAME_BITS - 1))
			begin
				// data byte: only writable bits, reserved drive codes keep old drive
				if (opcode == fxr_pkg::OP_SET_V || opcode == fxr_pkg::OP_SET_NV)
				begin
					if (opcode == fxr_pkg::OP_SET_V)
						next_vol[0] = byte_in[fxr_pkg::TP_BIT];
					else
						next_nv[0] = byte_in[fxr_pkg::TP_BIT];
					if (byte_in[7:5] != fxr_pkg::DRV_RSV_A && byte_in[7:5] != fxr_pkg::DRV_RSV_B)
					begin
						if (opcode == fxr_pkg::OP_SET_V)
							next_vol[3:1] = byte_in[7:5];
						else
							next_nv[3:1] = byte_in[7:5];
					end
				end
			end
		end
		else if (fall && bitcnt == 5'(fxr_pkg::BYTE_BITS) && opcode == fxr_pkg::OP_READ_EXT)
		begin
			// start driving the register only in the data byte
			next_oe = 1'b1;
			next_miso = reg_val[7];
			next_shout = {reg_val[6:0], 1'b0};
		end
		else if (fall && oe_q)
		begin
			next_miso = shout[7];
			next_shout = {shout[6:0], 1'b0};
		end
		// set wins over clear; flags never block commands
		next_flags = (flags & ~{fxr_pkg::FLAG_W{clr}}) | ev_set;
	end

	// register all state
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			vol <= fxr_pkg::WR_DEFAULT;
			nv <= fxr_pkg::WR_DEFAULT;
			flags <= 3'h0;
			reload <= 1'b1;
			bitcnt <= 5'h0;
			shin <= 15'h0;
			opcode <= 8'h00;
			shout <= 8'h00;
			miso_q <= 1'b0;
			oe_q <= 1'b0;
			dummy_cycles_out <= fxr_pkg::DUMMY_NONE;
			ext_params_out <= 8'h00;
			drive_sel_out <= fxr_pkg::DRV_30;
			training_pattern_enable_out <= 1'b0;
		end
		else
		begin
			vol <= next_vol;
			nv <= next_nv;
			flags <= next_flags;
			reload <= next_reload;
			bitcnt <= next_bitcnt;
			shin <= next_shin;
			opcode <= next_opcode;
			shout <= next_shout;
			miso_q <= next_miso;
			oe_q <= next_oe;
			dummy_cycles_out <= next_dummy;
			ext_params_out <= reg_val;
			drive_sel_out <= vol[3:1];
			training_pattern_enable_out <= vol[0];
		end
	end
endmodule : fxr_device

// *** verilog/fxr_host.sv ***
// controller end: command registers and serial frame sequencer
module fxr_host #(
	parameter int SCK_HALF = 8
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	// mode of the attached device
	input wire logic quad_mode_in,
	// link
	fxr_if.host link
);
	// state
	fxr_pkg::fxr_hstate_e state;
	fxr_pkg::fxr_hstate_e next_state;
	logic [7:0] half; // half period counter
	logic [7:0] next_half;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic [15:0] txsh;
	logic [15:0] next_txsh;
	logic [15:0] rx;
	logic [15:0] next_rx;
	logic [3:0] dummy; // programmed dummy count
	logic [3:0] next_dummy;
	logic refused; // sticky command refusal
	logic next_refused;
	logic sck_q;
	logic next_sck;
	logic cs_q;
	logic next_cs;
	logic mosi_q;
	logic next_mosi;
	logic [15:0] next_rdata;
	// miso synchroniser
	logic miso_s1; // first stage only
	logic miso_s2;
	logic half_done;
	logic [7:0] op_w;
	logic bad;

	assign half_done = half == 8'(SCK_HALF - 1);
	assign op_w = wdata_in[7:0];
	assign link.sck = sck_q;
	assign link.cs_n = cs_q;
	assign link.mosi = mosi_q;

	// sequencer, register writes and reads
	always_comb
	begin
		next_state = state;
		next_half = half;
		next_bitcnt = bitcnt;
		next_txsh = txsh;
		next_rx = rx;
		next_dummy = dummy;
		next_refused = refused;
		next_sck = sck_q;
		next_cs = cs_q;
		next_mosi = mosi_q;
		next_rdata = 16'h0000;
		// refuse busy, quad double-rate dual read, short dummy count
		bad = (state != fxr_pkg::HS_IDLE)
			| (quad_mode_in & (op_w == fxr_pkg::OP_DDR_DUAL_A | op_w == fxr_pkg::OP_DDR_DUAL_B))
			| (dummy < fxr_pkg::dummy_for(op_w, quad_mode_in));
		if (wr_in && addr_in == fxr_pkg::REG_STATUS)
			next_refused = 1'b0;
		if (wr_in && addr_in == fxr_pkg::REG_DUMMY)
			next_dummy = wdata_in[3:0];
		case (state)
			fxr_pkg::HS_IDLE:
			begin
				// start a frame, opcode first
				if (wr_in && addr_in == fxr_pkg::REG_CMD && !bad)
				begin
					next_state = fxr_pkg::HS_SHIFT;
					next_txsh = {op_w, wdata_in[15:8]};
					next_mosi = op_w[7];
					next_cs = 1'b0;
					next_sck = 1'b0;
					next_half = 8'h00;
					next_bitcnt = 4'h0;
				end
			end
			fxr_pkg::HS_SHIFT:
			begin
				next_half = half + 8'h01;
				if (half_done)
				begin
					next_half = 8'h00;
					next_sck = ~sck_q;
					if (!sck_q)
						next_rx = {rx[14:0], miso_s2};
					else if (bitcnt == 4'(fxr_pkg::FRAME_BITS - 1))
						next_state = fxr_pkg::HS_TAIL;
					else
					begin
						next_bitcnt = bitcnt + 4'h1;
						next_txsh = {txsh[14:0], 1'b0};
						next_mosi = txsh[14];
					end
				end
			end
			fxr_pkg::HS_TAIL:
			begin
				// hold select low so the device sees the last edge
				next_half = half + 8'h01;
				if (half_done)
				begin
					next_half = 8'h00;
					next_cs = 1'b1;
					next_state = fxr_pkg::HS_GUARD;
				end
			end
			fxr_pkg::HS_GUARD:
			begin
				next_half = half + 8'h01;
				if (half_done)
					next_state = fxr_pkg::HS_IDLE;
			end
			default: next_state = fxr_pkg::HS_IDLE;
		endcase
		// set wins over clear
		if (wr_in && addr_in == fxr_pkg::REG_CMD && bad)
			next_refused = 1'b1;
		if (rd_in)
		begin
			case (addr_in)
				fxr_pkg::REG_STATUS: next_rdata = {14'h0000, refused, state != fxr_pkg::HS_IDLE};
				fxr_pkg::REG_RX: next_rdata = rx;
				fxr_pkg::REG_DUMMY: next_rdata = {12'h000, dummy};
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	// register state; host never drives the device data line
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= fxr_pkg::HS_IDLE;
			half <= 8'h00;
			bitcnt <= 4'h0;
			txsh <= 16'h0000;
			rx <= 16'h0000;
			dummy <= fxr_pkg::DUMMY_8;
			refused <= 1'b0;
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			mosi_q <= 1'b0;
			rdata_out <= 16'h0000;
			miso_s1 <= 1'b0;
			miso_s2 <= 1'b0;
		end
		else
		begin
			state <= next_state;
			half <= next_half;
			bitcnt <= next_bitcnt;
			txsh <= next_txsh;
			rx <= next_rx;
			dummy <= next_dummy;
			refused <= next_refused;
			sck_q <= next_sck;
			cs_q <= next_cs;
			mosi_q <= next_mosi;
			rdata_out <= next_rdata;
			miso_s1 <= link.miso & link.miso_oe;
			miso_s2 <= miso_s1;
		end
	end
endmodule : fxr_host

// *** verification/fxr_link_sva.sv ***
// protocol checks on the serial link between host and device ends
module fxr_link_sva (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// link signals
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] n_rise; // link clock rises in current frame
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	// count link clock rises while the frame is open
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			n_rise <= 5'h0;
		else if (cs_n)
			n_rise <= 5'h0;
		else if ($rose(sck))
			n_rise <= n_rise + 5'h1;
	end
	property p_idle_clk;
		cs_n |-> !sck;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("link clock high outside frame");
	property p_lead;
		$fell(cs_n) |-> !sck [*6];
	endproperty
	a_lead: assert property (p_lead) else $error("link clock rose too early in frame");
	property p_high;
		$rose(sck) |-> sck [*6];
	endproperty
	a_high: assert property (p_high) else $error("link clock high phase too short");
	property p_mosi_hold;
		sck && !$rose(sck) |-> $stable(mosi);
	endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("host data moved while clock high");
	property p_frame_len;
		$rose(cs_n) |-> n_rise == 5'h10;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame not opcode plus data byte");
	property p_oe_start;
		$rose(miso_oe) |-> !cs_n && n_rise == 5'h8;
	endproperty
	a_oe_start: assert property (p_oe_start) else $error("device drove data out of turn");
	property p_oe_drop;
		$rose(cs_n) |-> ##[1:4] !miso_oe;
	endproperty
	a_oe_drop: assert property (p_oe_drop) else $error("device kept driving after frame");
	property p_miso_hold;
		miso_oe && sck && !$rose(sck) |-> $stable(miso);
	endproperty
	a_miso_hold: assert property (p_miso_hold) else $error("device data moved while clock high");
endmodule : fxr_link_sva

// *** verification/fxr_bench.sv ***
// self-checking bench joining host and device ends over the link
module flash_ext_read_reg_error_flags_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0; // system clock
	logic rst_n_in = 1'b0; // reset, active low
	logic [3:0] addr = 4'h0; // register port
	logic [15:0] wdata = 16'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic quad = 1'b0; // device mode
	logic busy = 1'b0; // array engine status
	logic wp_n = 1'b1;
	logic swd = 1'b0;
	logic [3:0] bp = 4'h0;
	logic ev = 1'b0; // outcome pulse
	fxr_pkg::fxr_event_e kind = fxr_pkg::EV_PROGRAM;
	logic ef = 1'b0;
	logic pf = 1'b0;
	logic pr = 1'b0;
	logic [7:0] ext; // device register view
	logic [2:0] drv;
	logic tpe;
	logic [3:0] dum;
	logic [2:0] flg = 3'h0; // expected erase, program, protect flags
	logic [3:0] wrb = 4'he; // expected writable bits
	logic [15:0] r; // last register read
	logic [7:0] rops [8] = '{8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'h0d, 8'hbd, 8'hed}; // read opcodes
	int errors = 0;
	int n_compared = 0;
	fxr_if link ();
	fxr_device fxr_device_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .link(link), .busy_in(busy),
		.quad_mode_in(quad), .write_protect_n_in(wp_n), .status_write_disable_in(swd), .block_protect_bits_in(bp),
		.event_valid_in(ev), .event_kind_in(kind), .erase_fail_in(ef), .program_fail_in(pf),
		.target_protected_in(pr), .ext_params_out(ext), .drive_sel_out(drv), .training_pattern_enable_out(tpe),
		.dummy_cycles_out(dum));
	fxr_host #(.SCK_HALF(6)) fxr_host_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .quad_mode_in(quad), .link(link));
	fxr_link_sva fxr_link_sva_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sck(link.sck),
		.cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
	// 40 MHz clock
	initial
	begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	// flags raised by one outcome
	function automatic logic [2:0] new_flags(input fxr_pkg::fxr_event_e k, input logic e, p, q, lk, b);
		case (k)
			fxr_pkg::EV_NV_UPDATE: return {e, p, 1'b0};
			fxr_pkg::EV_STATUS_WRITE: return {e | lk, p, lk};
			fxr_pkg::EV_ERASE: return {e | q, 1'b0, q};
			fxr_pkg::EV_CHIP_ERASE: return {e | b, 1'b0, b};
			default: return {1'b0, p | q, q};
		endcase
	endfunction : new_flags
	// default dummy count of a read opcode, none where quad mode lacks it
	function automatic logic [3:0] exp_dummy(input logic [7:0] op, input logic q);
		case (op)
			8'h3b, 8'h6b: return q ? 4'h0 : 4'h8;
			8'hbb, 8'hbd: return q ? 4'h0 : 4'h4;
			8'heb, 8'hed: return 4'h6;
			default: return q ? 4'h6 : 4'h8;
		endcase
	endfunction : exp_dummy
	// compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// counts and final verdict
	task automatic give_verdict();
		$display("compared=%0d errors=%0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	// one-cycle register write
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask : reg_wr
	// one-cycle register read, data in the next cycle
	task automatic reg_rd(input logic [3:0] a);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1 r = rdata;
	endtask : reg_rd
	// one link frame, polled to completion
	task automatic send(input logic [7:0] op, input logic [7:0] d);
		int i;
		reg_wr(fxr_pkg::REG_CMD, {d, op});
		for (i = 0; i < 200; i++)
		begin
			reg_rd(fxr_pkg::REG_STATUS);
			if (r[0] === 1'b0)
				break;
		end
		if (i == 200)
		begin
			errors++;
			give_verdict();
		end
		else
		begin
			repeat (8) @(posedge clk_sys_in);
			#1;
		end
	endtask : send
	// volatile parameter write and its expectation
	task automatic set_vol(input logic [7:0] d);
		send(fxr_pkg::OP_SET_V, d);
		if (d[7:5] != 3'h0 && d[7:5] != 3'h4)
			wrb[3:1] = d[7:5];
		wrb[0] = d[4];
		check({12'h0, drv, tpe}, {12'h0, wrb});
		check({8'h0, ext}, {8'h0, wrb, flg, busy});
	endtask : set_vol
	// one outcome with random qualifiers
	task automatic pulse(input fxr_pkg::fxr_event_e k);
		logic [4:0] v;
		v = 5'($urandom);
		@(posedge clk_sys_in);
		kind <= k;
		{ef, pf, pr, swd, wp_n} <= v;
		bp <= v[0] ? 4'($urandom) : 4'h0;
		busy <= 1'($urandom);
		repeat (3) @(posedge clk_sys_in);
		ev <= 1'b1;
		@(posedge clk_sys_in);
		ev <= 1'b0;
		flg = flg | new_flags(k, ef, pf, pr, swd & ~wp_n, |bp);
		repeat (2) @(posedge clk_sys_in);
		#1 check({8'h0, ext}, {8'h0, wrb, flg, busy});
	endtask : pulse
	// main sequence
	initial
	begin
		void'($urandom(32));
		repeat (4) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		#1 check({8'h0, ext}, 16'h00e0);
		reg_rd(fxr_pkg::REG_DUMMY);
		check(r, 16'h0008);
		for (int k = 0; k < 8; k++)
		begin
			for (int j = 0; j < 4; j++)
				pulse(fxr_pkg::fxr_event_e'(k));
			@(posedge clk_sys_in);
			busy <= 1'b0;
			set_vol(8'($urandom));
			send(fxr_pkg::OP_READ_EXT, 8'h0);
			reg_rd(fxr_pkg::REG_RX);
			check({8'h0, r[7:0]}, {8'h0, wrb, flg, 1'b0});
			send(fxr_pkg::OP_CLEAR_ERR, 8'h0);
			flg = 3'h0;
			check({8'h0, ext}, {8'h0, wrb, 4'h0});
		end
		set_vol(8'h1f);
		set_vol(8'h8f);
		set_vol(8'h20);
		pulse(fxr_pkg::EV_ERASE);
		@(posedge clk_sys_in);
		busy <= 1'b0;
		send(fxr_pkg::OP_SET_NV, 8'h3f);
		check({12'h0, drv, tpe}, {12'h0, wrb});
		send(fxr_pkg::OP_SOFT_RST, 8'h0);
		flg = 3'h0;
		check({8'h0, ext}, 16'h0030);
		wrb = 4'h3;
		reg_wr(fxr_pkg::REG_DUMMY, 16'h000f);
		for (int q = 0; q < 2; q++)
		begin
			@(posedge clk_sys_in);
			quad <= q[0];
			// quad mode only where the opcode has a quad default
			foreach (rops[i])
				if (!q[0] || exp_dummy(rops[i], 1'b1) != 4'h0)
				begin
					send(rops[i], 8'h0);
					check({12'h0, dum}, {12'h0, exp_dummy(rops[i], q[0])});
				end
		end
		reg_wr(fxr_pkg::REG_CMD, 16'h00bd);
		reg_rd(fxr_pkg::REG_STATUS);
		check(r, 16'h0002);
		check({15'h0, link.cs_n}, 16'h0001);
		reg_wr(fxr_pkg::REG_STATUS, 16'h0);
		quad <= 1'b0;
		reg_wr(fxr_pkg::REG_DUMMY, 16'h0003);
		reg_wr(fxr_pkg::REG_CMD, 16'h000b);
		reg_rd(fxr_pkg::REG_STATUS);
		check(r, 16'h0002);
		reg_wr(fxr_pkg::REG_STATUS, 16'h0);
		reg_rd(fxr_pkg::REG_STATUS);
		check(r, 16'h0000);
		// hardware reset in mid-run clears flags, restores default parameters and dummy count 8
		pulse(fxr_pkg::EV_UNLOCK);
		@(posedge clk_sys_in);
		rst_n_in <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		flg = 3'h0;
		wrb = fxr_pkg::WR_DEFAULT;
		repeat (4) @(posedge clk_sys_in);
		#1 check({8'h0, ext}, {8'h0, wrb, flg, busy});
		reg_rd(fxr_pkg::REG_DUMMY);
		check(r, 16'h0008);
		give_verdict();
	end
endmodule : flash_ext_read_reg_error_flags_bench
